// ===== verilog/mnpe_pkg.sv
package mnpe_pkg;

  // data path widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int STACK_W = 21;
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] STACK_DEPTH = 5'h1F;

  // register byte offsets on the APB port
  localparam logic [7:0] INSTR_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] PRODUCT_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] BANK_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  localparam logic [7:0] INDEX_OFS = 8'h18;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h1C;
  localparam logic [7:0] MEM_DATA_OFS = 8'h20;
  localparam logic [7:0] STACK_HEAD_OFS = 8'h24;
  localparam logic [7:0] STACK_PTR_OFS = 8'h28;

  // control register fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_UNSUP_BIT = 2;

  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PRODUCT_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  // instruction encodings
  localparam logic [7:0] MUL_LIT_PREFIX = 8'h0D;
  localparam logic [6:0] MUL_FILE_PREFIX = 7'h01;
  localparam logic [6:0] NEG_FILE_PREFIX = 7'h36;
  localparam logic [15:0] POP_WORD = 16'h0006;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [3:0] NOP_ALT_PREFIX = 4'hF;

  // operand addressing
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef struct packed {
    logic neg;
    logic signed_wrap_flag;
    logic zero;
    logic half_byte_carry_flag;
    logic carry;
  } mnpe_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mnpe_apb_req_t;

  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_COMPUTE, PH_WRITE} mnpe_phase_t;

  typedef enum logic [2:0] {OP_NONE, OP_MUL_LIT, OP_MUL_FILE, OP_NEG_FILE, OP_POP} mnpe_op_t;

endpackage

// ===== verilog/mnpe_core.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps

module mnpe_core (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input mnpe_pkg::mnpe_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import mnpe_pkg::*;

  logic rst_meta_reg;
  logic rst_n_sync_reg;

  mnpe_phase_t phase_reg;
  mnpe_phase_t phase_next;
  mnpe_op_t op_reg;
  mnpe_op_t op_dec;
  mnpe_flags_t flags_reg;
  mnpe_flags_t neg_flags;
  mnpe_flags_t neg_flags_reg;

  logic [15:0] instr_word_reg;
  logic [7:0] acc_reg;
  logic [7:0] multiply_result_high_reg;
  logic [7:0] multiply_result_low_reg;
  logic [3:0] bank_pointer_reg;
  logic ext_en_reg;
  logic unsup_reg;
  logic [ADDR_W-1:0] index_base_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [ADDR_W-1:0] eff_addr_reg;
  logic [7:0] operand_reg;
  logic [15:0] result_reg;
  logic [PTR_W-1:0] stack_ptr_reg;
  logic [31:0] prdata_reg;
  logic data_ok_reg;
  logic err_reg;

  logic [DATA_W-1:0] data_mem [0:(1<<ADDR_W)-1];
  logic [STACK_W-1:0] stack_mem [0:STACK_DEPTH-1];

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_sync_reg <= rst_meta_reg;
    end
  end

  // ---------------- apb decode ----------------
  wire busy = (phase_reg != PH_IDLE);
  wire apb_access = apb_req.psel & apb_req.penable;
  wire wr_done = apb_access & pready & apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire sel_instr = (addr == INSTR_OFS);
  wire sel_acc = (addr == ACC_OFS);
  wire sel_product = (addr == PRODUCT_OFS);
  wire sel_flags = (addr == FLAGS_OFS);
  wire sel_bank = (addr == BANK_OFS);
  wire sel_ctrl = (addr == CTRL_OFS);
  wire sel_index = (addr == INDEX_OFS);
  wire sel_mem_addr = (addr == MEM_ADDR_OFS);
  wire sel_mem_data = (addr == MEM_DATA_OFS);
  wire sel_stack_head = (addr == STACK_HEAD_OFS);
  wire sel_stack_ptr = (addr == STACK_PTR_OFS);
  wire mapped = sel_instr | sel_acc | sel_product | sel_flags | sel_bank | sel_ctrl
                | sel_index | sel_mem_addr | sel_mem_data | sel_stack_head | sel_stack_ptr;

  wire stack_empty = (stack_ptr_reg == 5'h00);
  wire [PTR_W-1:0] head_idx = stack_ptr_reg - 5'h01;
  wire [STACK_W-1:0] return_stack_head = stack_empty ? 21'h000000 : stack_mem[head_idx];

  wire [31:0] ctrl_view = {29'h00000000, unsup_reg, busy, ext_en_reg};

  wire [31:0] rd_mux =
    sel_instr ? {16'h0000, instr_word_reg} :
    sel_acc ? {24'h000000, acc_reg} :
    sel_product ? {16'h0000, multiply_result_high_reg, multiply_result_low_reg} :
    sel_flags ? {27'h0000000, flags_reg} :
    sel_bank ? {28'h0000000, bank_pointer_reg} :
    sel_ctrl ? ctrl_view :
    sel_index ? {20'h00000, index_base_reg} :
    sel_mem_addr ? {20'h00000, mem_addr_reg} :
    sel_mem_data ? {24'h000000, data_mem[mem_addr_reg]} :
    sel_stack_head ? {11'h000, return_stack_head} :
    sel_stack_ptr ? {27'h0000000, stack_ptr_reg} :
    32'h00000000;

  // the bus waits while an instruction runs, so software never races the datapath
  assign pready = apb_access & data_ok_reg & ~busy;
  assign pslverr = pready & err_reg;
  assign prdata = prdata_reg;

  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      prdata_reg <= 32'h00000000;
      data_ok_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else if (ce)
    begin
      data_ok_reg <= apb_req.psel & ~busy;
      err_reg <= ~mapped;
      if (apb_req.psel & ~busy)
      begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ---------------- instruction decode ----------------
  wire [7:0] f_addr = instr_word_reg[7:0];
  wire a_bit = instr_word_reg[8];
  wire is_nop = (instr_word_reg == NOP_WORD) || (instr_word_reg[15:12] == NOP_ALT_PREFIX);

  assign op_dec =
    (instr_word_reg[15:8] == MUL_LIT_PREFIX) ? OP_MUL_LIT :
    (instr_word_reg[15:9] == MUL_FILE_PREFIX) ? OP_MUL_FILE :
    (instr_word_reg[15:9] == NEG_FILE_PREFIX) ? OP_NEG_FILE :
    (instr_word_reg == POP_WORD) ? OP_POP :
    OP_NONE;

  // unknown words run as nop but leave a sticky mark for software
  wire unsup_dec = (op_dec == OP_NONE) & ~is_nop;

  wire indexed_sel = ext_en_reg & ~a_bit & (f_addr <= INDEXED_LIMIT);
  wire [ADDR_W-1:0] indexed_addr = index_base_reg + {4'h0, f_addr};
  wire [ADDR_W-1:0] banked_addr = {bank_pointer_reg, f_addr};
  wire [ADDR_W-1:0] access_addr = (f_addr < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f_addr}
                                                           : {ACCESS_HIGH_BANK, f_addr};
  wire [ADDR_W-1:0] eff_addr = indexed_sel ? indexed_addr : (a_bit ? banked_addr : access_addr);

  // ---------------- compute ----------------
  wire [7:0] mul_src = (op_reg == OP_MUL_LIT) ? instr_word_reg[7:0] : operand_reg;
  wire [15:0] product = acc_reg * mul_src;
  wire [7:0] inv_operand = ~operand_reg;
  wire [8:0] neg_sum = {1'b0, inv_operand} + 9'h001;
  wire [4:0] neg_half = {1'b0, inv_operand[3:0]} + 5'h01;

  assign neg_flags.neg = neg_sum[7];
  assign neg_flags.signed_wrap_flag = ~inv_operand[7] & neg_sum[7];
  assign neg_flags.zero = (neg_sum[7:0] == 8'h00);
  assign neg_flags.half_byte_carry_flag = neg_half[4];
  assign neg_flags.carry = neg_sum[8];

  // ---------------- phase sequencer ----------------
  wire instr_wr = wr_done & sel_instr;

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE: if (instr_wr) phase_next = PH_DECODE;
      PH_DECODE: phase_next = PH_READ;
      PH_READ: phase_next = PH_COMPUTE;
      PH_COMPUTE: phase_next = PH_WRITE;
      PH_WRITE: phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      phase_reg <= PH_IDLE;
    end
    else if (ce)
    begin
      phase_reg <= phase_next;
    end
  end

  wire in_decode = (phase_reg == PH_DECODE);
  wire in_read = (phase_reg == PH_READ);
  wire in_compute = (phase_reg == PH_COMPUTE);
  wire in_write = (phase_reg == PH_WRITE);
  wire mul_commit = in_write & ((op_reg == OP_MUL_LIT) | (op_reg == OP_MUL_FILE));
  wire neg_commit = in_write & (op_reg == OP_NEG_FILE);
  wire pop_commit = in_compute & (op_reg == OP_POP);

  // datapath staging: decode, operand fetch, compute
  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      op_reg <= OP_NONE;
      eff_addr_reg <= ADDR_RESET;
      operand_reg <= 8'h00;
      result_reg <= 16'h0000;
      neg_flags_reg <= mnpe_flags_t'(FLAGS_RESET);
    end
    else if (ce)
    begin
      if (in_decode)
      begin
        op_reg <= op_dec;
        eff_addr_reg <= eff_addr;
      end
      if (in_read)
      begin
        operand_reg <= data_mem[eff_addr_reg];
      end
      if (in_compute)
      begin
        result_reg <= (op_reg == OP_NEG_FILE) ? {8'h00, neg_sum[7:0]} : product;
        neg_flags_reg <= neg_flags;
      end
    end
  end

  // ---------------- architectural registers ----------------
  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      instr_word_reg <= INSTR_RESET;
      acc_reg <= ACC_RESET;
      multiply_result_high_reg <= PRODUCT_RESET;
      multiply_result_low_reg <= PRODUCT_RESET;
      flags_reg <= mnpe_flags_t'(FLAGS_RESET);
      bank_pointer_reg <= BANK_RESET;
      ext_en_reg <= 1'b0;
      index_base_reg <= ADDR_RESET;
      mem_addr_reg <= ADDR_RESET;
    end
    else if (ce)
    begin
      if (instr_wr)
        instr_word_reg <= apb_req.pwdata[15:0];
      if (wr_done & sel_acc)
        acc_reg <= apb_req.pwdata[7:0];
      if (mul_commit)
      begin
        multiply_result_high_reg <= result_reg[15:8];
        multiply_result_low_reg <= result_reg[7:0];
      end
      // only negate touches the flags; multiply, pop and nop leave them alone
      if (neg_commit)
        flags_reg <= neg_flags_reg;
      else if (wr_done & sel_flags)
        flags_reg <= mnpe_flags_t'(apb_req.pwdata[4:0]);
      if (wr_done & sel_bank)
        bank_pointer_reg <= apb_req.pwdata[3:0];
      if (wr_done & sel_ctrl)
        ext_en_reg <= apb_req.pwdata[CTRL_EXT_BIT];
      if (wr_done & sel_index)
        index_base_reg <= apb_req.pwdata[ADDR_W-1:0];
      if (wr_done & sel_mem_addr)
        mem_addr_reg <= apb_req.pwdata[ADDR_W-1:0];
    end
  end

  // sticky unsupported mark: write 1 to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      unsup_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (in_decode & unsup_dec)
        unsup_reg <= 1'b1;
      else if (wr_done & sel_ctrl & apb_req.pwdata[CTRL_UNSUP_BIT])
        unsup_reg <= 1'b0;
    end
  end

  // data memory has no reset; the bus and the datapath never write in the same cycle
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (neg_commit)
        data_mem[eff_addr_reg] <= result_reg[7:0];
      else if (wr_done & sel_mem_data)
        data_mem[mem_addr_reg] <= apb_req.pwdata[7:0];
    end
  end

  // return stack: software pushes through the head register, pop drops the head
  wire push_wr = wr_done & sel_stack_head & (stack_ptr_reg != STACK_DEPTH);

  always_ff @(posedge clk or negedge rst_n_sync_reg)
  begin
    if (!rst_n_sync_reg)
    begin
      stack_ptr_reg <= 5'h00;
    end
    else if (ce)
    begin
      if (pop_commit)
      begin
        // popping an empty stack is ignored rather than wrapping
        if (!stack_empty)
        begin
          stack_ptr_reg <= head_idx;
        end
      end
      else if (push_wr)
      begin
        stack_ptr_reg <= stack_ptr_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce & push_wr)
      stack_mem[stack_ptr_reg] <= apb_req.pwdata[STACK_W-1:0];
  end

endmodule

// ===== tb/mnpe_core_sva.sv
`timescale 1ns/100ps

module mnpe_core_sva
  import mnpe_pkg::*;
(
  input wire clk,
  input wire reset_n,
  input wire ce,
  input mnpe_pkg::mnpe_apb_req_t apb_req,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  logic [3:0] idle_cnt;
  wire acc_cyc = apb_req.psel && apb_req.penable;
  wire instr_done = acc_cyc && pready && apb_req.pwrite && apb_req.paddr == INSTR_OFS;

  // counts cycles since the last instruction start; saturates so a long idle stays idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      idle_cnt <= 4'h0;
    else if (instr_done)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF)
      idle_cnt <= idle_cnt + 4'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence instr_go_s;
    instr_done;
  endsequence

  sequence stall_s;
    acc_cyc && !pready;
  endsequence

  chk_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_ready_in_access: assert property (pready |-> acc_cyc)
    else $error("ready outside an access phase");
  chk_busy_stall: assert property (instr_go_s |=> !pready [*4])
    else $error("bus answered while instruction phases ran");
  chk_stall_bound: assert property (stall_s |-> ##[1:8] (pready || !apb_req.psel))
    else $error("instruction cycle did not finish in time");
  chk_idle_zero_wait: assert property ((apb_req.psel && !apb_req.penable && idle_cnt >= 4'hA) |=> pready)
    else $error("idle core inserted wait states");
  chk_release_quiet: assert property ($rose(reset_n) |-> !pready && prdata == 32'h0)
    else $error("bus active at reset release");
  chk_unmapped_err: assert property ((pready && apb_req.paddr > STACK_PTR_OFS) |->
    pslverr && (apb_req.pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property ((pready && apb_req.paddr <= STACK_PTR_OFS && apb_req.paddr[1:0] == 2'b00) |->
    !pslverr)
    else $error("mapped access refused");
endmodule

bind mnpe_core mnpe_core_sva i_sva (
  .clk(clk),
  .reset_n(reset_n),
  .ce(ce),
  .apb_req(apb_req),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);

// ===== tb/mnpe_host.sv
`timescale 1ns/100ps

module mnpe_host
  import mnpe_pkg::*;
(
  input wire clk,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  output mnpe_pkg::mnpe_apb_req_t apb_req
);
  initial
  begin
    apb_req = '0;
  end

  // request held until pready is seen high; data and error taken at that same edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (!pready)
      @(posedge clk);
    rdata = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end

module tb;
  import mnpe_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] fl;
    logic [3:0] bank;
    logic ext;
    logic [11:0] ma;
    logic [7:0] mv;
    logic [15:0] ins;
    logic [15:0] prod;
    logic [7:0] mem;
    logic [4:0] efl;
  } mnpe_row_t;

  // product carries over between rows: negate and nop must leave it alone
  mnpe_row_t rows [13] = '{
    '{8'hE2, 5'h1F, 4'h0, 1'b0, 12'h000, 8'h00, 16'h0DC4, 16'hAD08, 8'h00, 5'h1F},
    '{8'h00, 5'h00, 4'h0, 1'b0, 12'h000, 8'h00, 16'h0D55, 16'h0000, 8'h00, 5'h00},
    '{8'hFF, 5'h1F, 4'h0, 1'b0, 12'h000, 8'h00, 16'h0DFF, 16'hFE01, 8'h00, 5'h1F},
    '{8'hC4, 5'h0A, 4'h5, 1'b0, 12'h534, 8'hB5, 16'h0334, 16'h8A94, 8'hB5, 5'h0A},
    '{8'h03, 5'h00, 4'h0, 1'b0, 12'hF70, 8'h10, 16'h0270, 16'h0030, 8'h10, 5'h00},
    '{8'h02, 5'h00, 4'h0, 1'b0, 12'h020, 8'h07, 16'h0220, 16'h000E, 8'h07, 5'h00},
    '{8'h04, 5'h00, 4'h0, 1'b1, 12'h35F, 8'h11, 16'h025F, 16'h0044, 8'h11, 5'h00},
    '{8'h05, 5'h00, 4'h0, 1'b1, 12'hF60, 8'h03, 16'h0260, 16'h000F, 8'h03, 5'h00},
    '{8'h01, 5'h1F, 4'h2, 1'b0, 12'h23A, 8'h3A, 16'h6D3A, 16'h000F, 8'hC6, 5'h10},
    '{8'h01, 5'h00, 4'h0, 1'b0, 12'h010, 8'h00, 16'h6C10, 16'h000F, 8'h00, 5'h07},
    '{8'h01, 5'h00, 4'h0, 1'b1, 12'h305, 8'h80, 16'h6C05, 16'h000F, 8'h80, 5'h1A},
    '{8'h77, 5'h15, 4'h0, 1'b0, 12'h011, 8'h42, 16'h0000, 16'h000F, 8'h42, 5'h15},
    '{8'h77, 5'h15, 4'h0, 1'b0, 12'h011, 8'h42, 16'hF123, 16'h000F, 8'h42, 5'h15}
  };

  logic clk;
  logic reset_n;
  logic ce;
  mnpe_apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdata;
  logic err;
  int n_errors;
  int check_count;

  mnpe_core i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  mnpe_host i_host (
    .clk(clk),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .apb_req(apb_req)
  );

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
  end

  always #20 clk = ~clk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rdata, err);
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rdata, err);
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ACC_OFS);
    `CHK(rdata[7:0], ACC_RESET)
    rd(PRODUCT_OFS);
    `CHK(rdata[15:0], 16'h0000)
    rd(FLAGS_OFS);
    `CHK(rdata[4:0], FLAGS_RESET)
    wr(INDEX_OFS, 32'h300);
    foreach (rows[i])
    begin
      wr(ACC_OFS, {24'h0, rows[i].acc});
      wr(FLAGS_OFS, {27'h0, rows[i].fl});
      wr(BANK_OFS, {28'h0, rows[i].bank});
      wr(CTRL_OFS, {31'h0, rows[i].ext});
      wr(MEM_ADDR_OFS, {20'h0, rows[i].ma});
      wr(MEM_DATA_OFS, {24'h0, rows[i].mv});
      wr(INSTR_OFS, {16'h0, rows[i].ins});
      rd(PRODUCT_OFS);
      `CHK(rdata[15:0], rows[i].prod)
      rd(FLAGS_OFS);
      `CHK(rdata[4:0], rows[i].efl)
      rd(MEM_DATA_OFS);
      `CHK(rdata[7:0], rows[i].mem)
      rd(ACC_OFS);
      `CHK(rdata[7:0], rows[i].acc)
    end
    wr(STACK_HEAD_OFS, 32'h11111);
    wr(STACK_HEAD_OFS, 32'h14332);
    wr(STACK_HEAD_OFS, 32'h31A2);
    wr(FLAGS_OFS, 32'h15);
    wr(INSTR_OFS, {16'h0, POP_WORD});
    rd(STACK_HEAD_OFS);
    `CHK(rdata[20:0], 21'h014332)
    rd(STACK_PTR_OFS);
    `CHK(rdata[4:0], 5'h02)
    rd(FLAGS_OFS);
    `CHK(rdata[4:0], 5'h15)
    // the nop rows above must not have raised the unsupported mark
    rd(CTRL_OFS);
    `CHK(rdata[CTRL_UNSUP_BIT], 1'h0)
    wr(INSTR_OFS, 32'h00000007);
    rd(CTRL_OFS);
    `CHK(rdata[CTRL_UNSUP_BIT], 1'h1)
    rd(PRODUCT_OFS);
    `CHK(rdata[15:0], 16'h000F)
    wr(CTRL_OFS, 32'h00000004);
    rd(CTRL_OFS);
    `CHK(rdata[2:0], 3'h0)
    // second reset in mid-run: state must return to its reset values
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(STACK_PTR_OFS);
    `CHK(rdata[4:0], 5'h00)
    rd(FLAGS_OFS);
    `CHK(rdata[4:0], FLAGS_RESET)
    rd(PRODUCT_OFS);
    `CHK(rdata[15:0], {PRODUCT_RESET, PRODUCT_RESET})
    rd(ACC_OFS);
    `CHK(rdata[7:0], ACC_RESET)
    rd(8'h40);
    `CHK({err, rdata}, {1'b1, 32'h0})
    final_report();
  end
endmodule
